// [design/atsc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "atsc_cfg.svh"
module atsc_ctrl
    import atsc_pkg::*;
#(
    parameter int WORD_BITS = `ATSC_WORD_BITS,
    parameter int HALF_DIV = `ATSC_HALF_DIV
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET,
    // Link to the attenuator unit.
    atsc_if.ctrl LINK,
    // User request: word and channel, taken when START is high while the sequencer is idle (READY is still low in the first cycle after reset).
    input wire logic START,
    input wire logic [1:0] CHANNEL,
    input wire logic [WORD_BITS-1:0] WORD,
    output logic READY,
    output logic DONE,
    // Revision seen: high for current (grounded) version.
    output logic REV_CURRENT,
    // Serial output of the addressed channel, shifted in one bit on each falling shift clock edge of a transfer.
    output logic [WORD_BITS-1:0] READBACK
);
    localparam int CW = $clog2(HALF_DIV + 1);
    atsc_state_t state_ff, nxt_state;
    logic [CW-1:0] div_ff;
    logic tick;
    logic [WORD_BITS-1:0] word_ff, rb_ff;
    logic [3:0] bit_ff;
    logic [1:0] chan_ff;
    logic sclk_ff, sdat_ff, ready_ff, done_ff;
    logic [3:0] strobe_ff;
    // Revision sense synchroniser and filtered level.
    logic rs1_ff, rs2_ff, rs3_ff, rev_ff;
    // Selected channel's shift output.
    logic sel_out;
    assign sel_out = (chan_ff == 2'd0) ? LINK.longitudinal_shift_out :
                     (chan_ff == 2'd1) ? LINK.vertical_shift_out :
                     (chan_ff == 2'd2) ? LINK.horizontal_shift_out : LINK.backend_shift_out;
    // Divider tick gives the half period of the shift clock.
    // Rate limit.
    assign tick = (div_ff == CW'(HALF_DIV - 1));
    always_ff @(posedge CLK) begin
        if (RESET || state_ff == ATSC_IDLE || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Next state of the sequencer.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ATSC_IDLE: if (START) nxt_state = ATSC_LOW;
            ATSC_LOW: if (tick) nxt_state = ATSC_HIGH;
            ATSC_HIGH: if (tick) nxt_state = (bit_ff == 4'(WORD_BITS - 1)) ? ATSC_GAP : ATSC_LOW;
            ATSC_GAP: if (tick) nxt_state = ATSC_STROBE;
            ATSC_STROBE: if (tick && bit_ff == 4'(`ATSC_STROBE_HALVES - 1)) nxt_state = ATSC_DONE;
            ATSC_DONE: nxt_state = ATSC_IDLE;
        endcase
    end

    // Sequencer registers: shift MSB first, then pulse one strobe.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_ff <= ATSC_IDLE;
            word_ff <= '0;
            bit_ff <= 4'h0;
            chan_ff <= 2'h0;
            sclk_ff <= 1'b0;
            sdat_ff <= 1'b0;
            strobe_ff <= 4'h0;
            done_ff <= 1'b0;
            ready_ff <= 1'b0;
            rb_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            done_ff <= (state_ff == ATSC_DONE);
            ready_ff <= (nxt_state == ATSC_IDLE);
            if (state_ff == ATSC_IDLE && START) begin
                word_ff <= WORD;
                chan_ff <= CHANNEL;
                bit_ff <= 4'h0;
                sdat_ff <= WORD[WORD_BITS-1];
            end
            if (tick && state_ff == ATSC_LOW) begin
                sclk_ff <= 1'b1;
            end
            if (tick && state_ff == ATSC_HIGH) begin
                sclk_ff <= 1'b0;
                rb_ff <= {rb_ff[WORD_BITS-2:0], sel_out};
                word_ff <= {word_ff[WORD_BITS-2:0], 1'b0};
                sdat_ff <= word_ff[WORD_BITS-2];
                bit_ff <= (bit_ff == 4'(WORD_BITS - 1)) ? 4'h0 : bit_ff + 4'h1;
            end
            if (tick && state_ff == ATSC_GAP) begin
                strobe_ff <= 4'h1 << chan_ff;
            end
            if (tick && state_ff == ATSC_STROBE) begin
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'(`ATSC_STROBE_HALVES - 1)) begin
                    strobe_ff <= 4'h0;
                end
            end
        end
    end

    // Revision sense: three flops, level changes when stages two and three agree.
    // Detect revision.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rs1_ff <= 1'b1;
            rs2_ff <= 1'b1;
            rs3_ff <= 1'b1;
            rev_ff <= 1'b0;
        end else begin
            rs1_ff <= LINK.revision_sense;
            rs2_ff <= rs1_ff;
            rs3_ff <= rs2_ff;
            if (rs2_ff == rs3_ff) begin
                rev_ff <= ~rs3_ff;
            end
        end
    end

    assign LINK.atten_shift_clock = sclk_ff;
    assign LINK.atten_shift_data_in = sdat_ff;
    assign LINK.longitudinal_latch_strobe = strobe_ff[`ATSC_CH_LONG];
    assign LINK.vertical_latch_strobe = strobe_ff[`ATSC_CH_VERT];
    assign LINK.horizontal_latch_strobe = strobe_ff[`ATSC_CH_HOR];
    assign LINK.backend_latch_strobe = strobe_ff[`ATSC_CH_BE];
    assign READY = ready_ff;
    assign DONE = done_ff;
    assign REV_CURRENT = rev_ff;
    assign READBACK = rb_ff;
endmodule : atsc_ctrl
`default_nettype wire

// [shared/atsc_cfg.svh]
`ifndef ATSC_CFG_SVH
`define ATSC_CFG_SVH
// Width of one attenuator control word.
`define ATSC_WORD_BITS 8
// Number of attenuator channels: longitudinal, vertical, horizontal, back end.
`define ATSC_NUM_CHAN 4
// Channel indices.
`define ATSC_CH_LONG 0
`define ATSC_CH_VERT 1
`define ATSC_CH_HOR 2
`define ATSC_CH_BE 3
// Serial clock limits and preferred rate in kHz.
`define ATSC_SCLK_MAX_KHZ 30000
`define ATSC_SCLK_PREF_KHZ 1500
// System clock rate in kHz.
`define ATSC_CLK_KHZ 125000
// Half period of the controller-made shift clock in system cycles (rounded up, at least one).
`define ATSC_HALF_DIV ((`ATSC_CLK_KHZ + 2 * `ATSC_SCLK_PREF_KHZ - 1) / (2 * `ATSC_SCLK_PREF_KHZ))
// Latch strobe width in half periods of the shift clock.
`define ATSC_STROBE_HALVES 2
`endif

// [shared/atsc_pkg.sv]
package atsc_pkg;
    // Controller sequencing states.
    typedef enum logic [2:0] {
        ATSC_IDLE,
        ATSC_LOW,
        ATSC_HIGH,
        ATSC_GAP,
        ATSC_STROBE,
        ATSC_DONE
    } atsc_state_t;
    // One control word.
    typedef logic [7:0] atsc_word_t;
endpackage : atsc_pkg

// [shared/atsc_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Wires between the attenuator unit and its controller.
interface atsc_if;
    // Shared serial clock to all attenuators.
    logic atten_shift_clock;
    // Shared serial data to all attenuators.
    logic atten_shift_data_in;
    // Per-channel latch strobes, active high.
    logic longitudinal_latch_strobe;
    logic vertical_latch_strobe;
    logic horizontal_latch_strobe;
    logic backend_latch_strobe;
    // Per-channel shift register outputs.
    logic longitudinal_shift_out;
    logic vertical_shift_out;
    logic horizontal_shift_out;
    logic backend_shift_out;
    // Revision sense: output value and its enable, low while driven.
    logic revision_sense_o;
    logic revision_sense_oe_n;
    // Level seen on the wire; floating reads high through an assumed pull-up.
    logic revision_sense;
    assign revision_sense = revision_sense_oe_n ? 1'b1 : revision_sense_o;
    // The attenuator unit drives outputs and reads the controller's lines.
    modport unit (
        input atten_shift_clock, atten_shift_data_in,
        input longitudinal_latch_strobe, vertical_latch_strobe,
        input horizontal_latch_strobe, backend_latch_strobe,
        output longitudinal_shift_out, vertical_shift_out,
        output horizontal_shift_out, backend_shift_out,
        output revision_sense_o, revision_sense_oe_n
    );
    // The controller drives clock, data, strobes and reads the four shift outputs and the revision sense level.
    modport ctrl (
        output atten_shift_clock, atten_shift_data_in,
        output longitudinal_latch_strobe, vertical_latch_strobe,
        output horizontal_latch_strobe, backend_latch_strobe,
        input longitudinal_shift_out, vertical_shift_out,
        input horizontal_shift_out, backend_shift_out,
        input revision_sense
    );
endinterface : atsc_if
`default_nettype wire

// [design/atsc_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "atsc_cfg.svh"
module atsc_unit
    import atsc_pkg::*;
#(
    parameter int WORD_BITS = `ATSC_WORD_BITS
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET,
    // Link to the controller.
    atsc_if.unit LINK,
    // Applied settings, one word per channel.
    output logic [WORD_BITS-1:0] LONG_SETTING,
    output logic [WORD_BITS-1:0] VERT_SETTING,
    output logic [WORD_BITS-1:0] HOR_SETTING,
    output logic [WORD_BITS-1:0] BE_SETTING
);
    // Number of attenuator channels served by the shared lines.
    localparam int NCH = `ATSC_NUM_CHAN;

    // The controller's six lines arrive from another clock domain, so they are
    // gathered into one vector and filtered together.  Bit zero is the shift
    // clock, bit one the shift data, and bits two to five the latch strobes in
    // channel order: longitudinal, vertical, horizontal, back end.
    // Filtering all six with the same depth keeps their relative timing, which
    // matters because data must be seen settled when the clock edge is found.
    // The price is a fixed latency of about four system cycles per edge, so the
    // controller's half period must stay above that figure.
    // Raw pin vector: clock, data, then four strobes.
    logic [5:0] pins_raw;
    assign pins_raw = {LINK.backend_latch_strobe, LINK.horizontal_latch_strobe,
                       LINK.vertical_latch_strobe, LINK.longitudinal_latch_strobe,
                       LINK.atten_shift_data_in, LINK.atten_shift_clock};
    // Three-stage synchroniser; stage one is read only by stage two.
    // First stage; may go metastable, so only stage two reads it.
    logic [5:0] sync1_ff;
    // Second stage; first settled copy of the pins.
    logic [5:0] sync2_ff;
    // Third stage; compared with stage two to reject single-cycle glitches.
    logic [5:0] sync3_ff;
    // A line only changes its filtered level when the last two stages agree.
    // A spike shorter than one system cycle is therefore ignored, which helps on
    // a long cable; the cost is that the shift clock may not run faster than a
    // few system cycles per half period.
    // Debounced level, updated only when stages two and three agree.
    logic [5:0] level_ff;
    logic [5:0] nxt_level;
    assign nxt_level = (sync2_ff & sync3_ff) | (level_ff & (sync2_ff | sync3_ff));
    // Shift registers, one per attenuator, and applied settings.
    logic [WORD_BITS-1:0] shreg_ff [NCH];
    logic [WORD_BITS-1:0] set_ff [NCH];
    // Registered serial outputs.
    logic [NCH-1:0] sout_ff;
    // Edge detection on the filtered levels.
    // The filtered levels reset low, the idle level of every controller line,
    // so no false edge appears when reset is released.  A shift clock or a
    // strobe that is already high at release is seen as a rising edge once it
    // has passed the filter; that is a limitation the controller must respect.
    // Rising shift clock in this cycle.
    logic sclk_rise;
    logic [NCH-1:0] strobe_rise;
    assign sclk_rise = nxt_level[0] & ~level_ff[0];
    assign strobe_rise = nxt_level[5:2] & ~level_ff[5:2];

    // Input sampling; the unit only reads these lines, never drives them.
    // All stages reset low so the filter starts in the idle state of the link.
    // The level register is updated every cycle from the agreement logic above.
    // Keeping the whole filter in one process makes the stage order obvious.
    // Lines are inputs.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
            sync3_ff <= 6'h00;
            level_ff <= 6'h00;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
        end
    end

    // Every attenuator shifts the same bit on each rising shift clock, MSB first.
    // The data bit is taken from the filtered level in the same cycle that the
    // clock edge is found.  Clock and data pass through identical filters, so a
    // data change made on the falling clock edge is settled long before the
    // next rising edge is seen.  Each channel has its own register even though
    // all four always hold the same bits; this mirrors four separate devices
    // and lets each serial output be checked on its own pin.
    // Eight rising edges load one whole word; extra edges simply push the
    // oldest bits out, so only the last eight bits before a strobe count.
    // Loop index over the channels.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    shreg_ff[g] <= '0;
                end else if (sclk_rise) begin
                    shreg_ff[g] <= {shreg_ff[g][WORD_BITS-2:0], level_ff[1]};
                end
            end
            // Strobe rising edge copies the shifted word; a strobe held high
            // during shifting does not re-latch, which is why order matters.
            // Latching on the edge rather than the level means a word that is
            // still being shifted never reaches the applied setting, even if
            // the controller leaves a strobe high by mistake.  The setting
            // stays until the next rising strobe on the same channel; the
            // other channels are untouched.
            // Per-channel latch.
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    set_ff[g] <= '0;
                end else if (strobe_rise[g]) begin
                    set_ff[g] <= shreg_ff[g];
                end
            end
            // The bit falling out of each register is visible on its own pin.
            // It is registered once more so the pin comes straight from a
            // flip-flop.  During a transfer the previous word appears here MSB
            // first, one bit per shift, which lets the controller confirm the
            // path through every attenuator.
            // Serial output.
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    sout_ff[g] <= 1'b0;
                end else begin
                    sout_ff[g] <= shreg_ff[g][WORD_BITS-1];
                end
            end
        end
    endgenerate

    // Outputs straight from flip-flops.
    // The channel indices come from the shared constants so that the
    // controller's strobe bits and the unit's outputs agree on the order.
    assign LINK.longitudinal_shift_out = sout_ff[`ATSC_CH_LONG];
    assign LINK.vertical_shift_out = sout_ff[`ATSC_CH_VERT];
    assign LINK.horizontal_shift_out = sout_ff[`ATSC_CH_HOR];
    assign LINK.backend_shift_out = sout_ff[`ATSC_CH_BE];
    assign LONG_SETTING = set_ff[`ATSC_CH_LONG];
    assign VERT_SETTING = set_ff[`ATSC_CH_VERT];
    assign HOR_SETTING = set_ff[`ATSC_CH_HOR];
    assign BE_SETTING = set_ff[`ATSC_CH_BE];

    // Revision sense is a constant ground, driven from reset onward.
    // These registers have no reset branch on purpose: they load constants on
    // every edge, so the pin is grounded from the first clock even while reset
    // is held.  A floating pin would read high and mark the legacy version.
    // Value driven onto the sense pin.
    logic rev_o_ff;
    // Output enable of the sense pin, low while driving.
    logic rev_oe_n_ff;
    always_ff @(posedge CLK) begin
        rev_o_ff <= 1'b0;
        rev_oe_n_ff <= 1'b0;
    end
    assign LINK.revision_sense_o = rev_o_ff;
    assign LINK.revision_sense_oe_n = rev_oe_n_ff;
endmodule : atsc_unit
`default_nettype wire

// [dv/atsc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the wires between the attenuator unit and its controller.
module atsc_monitor #(
    parameter int HALF_DIV = 4
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET,
    // Lines the controller drives.
    input wire logic atten_shift_clock,
    input wire logic atten_shift_data_in,
    input wire logic longitudinal_latch_strobe,
    input wire logic vertical_latch_strobe,
    input wire logic horizontal_latch_strobe,
    input wire logic backend_latch_strobe,
    // Lines the unit drives.
    input wire logic longitudinal_shift_out,
    input wire logic vertical_shift_out,
    input wire logic horizontal_shift_out,
    input wire logic backend_shift_out,
    input wire logic revision_sense_o,
    input wire logic revision_sense_oe_n,
    input wire logic revision_sense
);
    // High while any channel strobe is up.
    wire logic any_strobe = longitudinal_latch_strobe | vertical_latch_strobe |
        horizontal_latch_strobe | backend_latch_strobe;
    // Counts clock cycles the shift clock has stayed high.
    logic [7:0] hi_cnt_ff;
    // A counter is used because the half period is a parameter.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= atten_shift_clock ? hi_cnt_ff + 8'h01 : 8'h00;
        end
    end
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RESET);
    // A strobe is high for two half periods, eight cycles with the bench divider.
    sequence s_strobe_pulse;
        any_strobe [*8] ##1 !any_strobe;
    endsequence
    property p_sense_low;
        revision_sense == 1'b0 && revision_sense_oe_n == 1'b0;
    endproperty
    a_sense_low: assert property (p_sense_low) else $error("revision sense not grounded");
    property p_one_strobe;
        $onehot0({longitudinal_latch_strobe, vertical_latch_strobe, horizontal_latch_strobe, backend_latch_strobe});
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("more than one strobe high");
    property p_strobe_pulse;
        $rose(any_strobe) |-> s_strobe_pulse;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe pulse width wrong");
    property p_quiet_clock;
        any_strobe |-> !atten_shift_clock;
    endproperty
    a_quiet_clock: assert property (p_quiet_clock) else $error("shift clock high under strobe");
    property p_clock_half;
        $fell(atten_shift_clock) |-> hi_cnt_ff == HALF_DIV;
    endproperty
    a_clock_half: assert property (p_clock_half) else $error("shift clock high time wrong");
    property p_data_hold;
        atten_shift_clock && $past(atten_shift_clock) |-> $stable(atten_shift_data_in);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_outs_match;
        longitudinal_shift_out == vertical_shift_out && horizontal_shift_out == backend_shift_out &&
        vertical_shift_out == horizontal_shift_out;
    endproperty
    a_outs_match: assert property (p_outs_match) else $error("shift outputs differ");
    property p_out_still;
        any_strobe |-> $stable(backend_shift_out) && $stable(longitudinal_shift_out);
    endproperty
    a_out_still: assert property (p_out_still) else $error("shift output moved with no clock");
endmodule : atsc_monitor
`default_nettype wire

// [dv/atsc_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// Compares a value with its expectation and counts both outcomes.
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module atsc_bench;
    // User side of the controller and applied settings of the unit.
    logic clk, reset, start, ready, done, rev_current;
    logic [1:0] channel;
    logic [7:0] word, readback, prev;
    logic [7:0] setting [4];
    logic [7:0] exp_set [4];
    int miscompares, n_tests, i;
    atsc_if link_if();
    atsc_ctrl #(.HALF_DIV(4)) atsc_ctrl_inst (.CLK(clk), .RESET(reset), .LINK(link_if.ctrl), .START(start),
        .CHANNEL(channel), .WORD(word), .READY(ready), .DONE(done), .REV_CURRENT(rev_current), .READBACK(readback));
    atsc_unit atsc_unit_inst (.CLK(clk), .RESET(reset), .LINK(link_if.unit), .LONG_SETTING(setting[0]),
        .VERT_SETTING(setting[1]), .HOR_SETTING(setting[2]), .BE_SETTING(setting[3]));
    atsc_monitor #(.HALF_DIV(4)) atsc_monitor_inst (.CLK(clk), .RESET(reset),
        .atten_shift_clock(link_if.atten_shift_clock), .atten_shift_data_in(link_if.atten_shift_data_in),
        .longitudinal_latch_strobe(link_if.longitudinal_latch_strobe),
        .vertical_latch_strobe(link_if.vertical_latch_strobe),
        .horizontal_latch_strobe(link_if.horizontal_latch_strobe),
        .backend_latch_strobe(link_if.backend_latch_strobe),
        .longitudinal_shift_out(link_if.longitudinal_shift_out), .vertical_shift_out(link_if.vertical_shift_out),
        .horizontal_shift_out(link_if.horizontal_shift_out), .backend_shift_out(link_if.backend_shift_out),
        .revision_sense_o(link_if.revision_sense_o), .revision_sense_oe_n(link_if.revision_sense_oe_n),
        .revision_sense(link_if.revision_sense));
    // System clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // Waits on falling edges for a flag, giving up after a bound.
    task automatic wait_high(input string what, ref logic flag);
        for (int k = 0; k < 400 && flag !== 1'b1; k++) @(negedge clk);
        `CHK(what, 1'b1, flag)
    endtask : wait_high
    // Sends one word; with poke set, a second start is tried while busy and must be ignored.
    task automatic send(input logic [1:0] ch, input logic [7:0] w, input bit poke);
        wait_high("ready", ready);
        channel = ch;
        word = w;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        if (poke) begin
            repeat (10) @(negedge clk);
            channel = ch + 2'h1;
            word = ~w;
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
        end
        wait_high("done", done);
        repeat (8) @(negedge clk);
        exp_set[ch] = w;
        for (int j = 0; j < 4; j++) `CHK("setting", exp_set[j], setting[j])
        // The registers still hold the previous word, which falls out MSB first during this transfer.
        `CHK("readback", prev, readback)
        prev = w;
    endtask : send
    // Main sequence: reset, revision, then every channel with edge values.
    initial begin
        reset = 1'b1;
        start = 1'b0;
        channel = 2'h0;
        word = 8'h00;
        prev = 8'h00;
        miscompares = 0;
        n_tests = 0;
        for (i = 0; i < 4; i++) exp_set[i] = 8'h00;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        for (i = 0; i < 4; i++) `CHK("reset setting", 8'h00, setting[i])
        repeat (8) @(negedge clk);
        `CHK("revision", 1'b1, rev_current)
        send(2'h0, 8'hA5, 1'b0);
        send(2'h1, 8'h3C, 1'b1);
        send(2'h2, 8'hFF, 1'b0);
        send(2'h3, 8'h00, 1'b0);
        send(2'h3, 8'h81, 1'b0);
        print_verdict();
    end
    // Five transfers take about 4 us; a hang is cut off well beyond that.
    initial begin
        #50000;
        miscompares++;
        print_verdict();
    end
endmodule : atsc_bench
`default_nettype wire
